//--- src/frwp_consts.vh
// Register offsets, field positions, codes, keys and erased value of the flash row/word programmer
`ifndef FRWP_CONSTS_VH
`define FRWP_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FRWP_OFF_CTRL     8'h00
`define FRWP_OFF_KEY      8'h04
`define FRWP_OFF_DEST_LO  8'h08
`define FRWP_OFF_DEST_HI  8'h0C
`define FRWP_OFF_SRC      8'h10
`define FRWP_OFF_TABLE_PAGE_REG   8'h14
`define FRWP_OFF_TBL_EA   8'h18
`define FRWP_OFF_TBL_LO   8'h1C
`define FRWP_OFF_TBL_HI   8'h20
`define FRWP_OFF_TBL_LO_B 8'h24
`define FRWP_OFF_TBL_HI_B 8'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define FRWP_BIT_WR    15
`define FRWP_BIT_PROG_ERASE_ENABLE  14
`define FRWP_BIT_SEQUENCE_ERROR_FLAG 13
`define FRWP_BIT_ROW_DATA_PACKED  9
`define FRWP_BIT_UNDERRUN_ERROR_FLAG 8
`define FRWP_OP_MSB    3

// ----------------------------------------------------------------
// Operation codes, keys and constants
// ----------------------------------------------------------------
`define FRWP_OP_DWORD  4'h1
`define FRWP_OP_ROW    4'h2
`define FRWP_OP_PAGE   4'h3
`define FRWP_OP_PART   4'h4
`define FRWP_KEY_FIRST 8'h55
`define FRWP_KEY_SECOND 8'hAA
`define FRWP_LATCH_PAGE 8'hFA
`define FRWP_ERASED    24'hFFFFFF
`define FRWP_PHANTOM   8'h00

`endif

//--- src/frwp_top.v
// Flash row/word self-programming engine with AHB-Lite register slave and flash array
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Summary of operation
// - Programming only clears bits; array word becomes old AND new data.
// - Table writes only load holding latches at the FAxxxx page.
// - Programming starts only from unlock and start, never from latch loads.
// - Word programming writes two latched words as one aligned pair, one word per cycle over two cycles.
// - Row and page sizes are parameters, default 64 and 512 words.
// - Latch row cycle: 64 low and 64 high writes, unlock, start.
// - RAM row programming fetches source data from the source address.
// - Packed format: one data word holds both upper bytes of a pair.
// - Unpacked format: two data words per program word, upper half zero.
// - Control bit 9 selects packed (one) or unpacked (zero) buffer format.
// - Engine moves buffered data itself and steps the destination address.
// - Source underrun found at start keeps the operation from starting and sets control bit 8.
// - Two table-write latches stay available for word programming.
// - Key 55h then AAh allows a start (write-start bit) on the one following write.
// - Op codes: 1 double word, 2 row, 3 page erase, 4 partition erase.
// - Start with a reserved op sets sequence error, no operation.
// - Write-start bit clears itself when the operation completes.
`include "frwp_consts.vh"

module frwp_top #(
    parameter AW = 10,
    parameter ROW_WORDS = 64,
    parameter PAGE_WORDS = 512,
    parameter RAM_WORDS = 32768,
    parameter RAM_ROW = 1
) (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output reg ram_req,
    output reg [15:0] ram_addr,
    input wire [15:0] ram_rdata,
    input wire ram_ack,
    output wire busy
);

// ----------------------------------------------------------------
// States and storage
// ----------------------------------------------------------------
localparam ST_IDLE = 3'd0;
localparam ST_DWORD = 3'd1;
localparam ST_ROWL = 3'd2;
localparam ST_FETCH = 3'd3;
localparam ST_ERASE = 3'd4;
localparam ARRAY_WORDS = 1 << AW;

reg [23:0] flash_mem [0:ARRAY_WORDS-1];
reg [23:0] latch_mem [0:ROW_WORDS-1];

reg [2:0] state_reg;
reg [15:0] cnt_reg;
reg [15:0] last_reg;
reg [AW-1:0] base_reg;
reg [1:0] ph_reg;
reg [15:0] lo_reg;
reg [15:0] hi_reg;
reg wr_reg, prog_erase_enable_reg, sequence_error_flag_reg, row_data_packed_reg, underrun_error_flag_reg;
reg [3:0] op_reg;
reg key_stage_reg;
reg window_reg;
reg [15:0] dest_lo_reg;
reg [7:0] dest_hi_reg;
reg [15:0] src_reg;
reg [7:0] table_page_reg_reg;
reg [15:0] ea_reg;
reg [7:0] dph_addr_reg;
reg dph_wr_reg;
reg rd_pend_reg;

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [7:0] sel_byte;
    input [15:0] w;
    input b;
    begin
        sel_byte = b ? w[15:8] : w[7:0];
    end
endfunction

wire [23:0] dest_addr = {dest_hi_reg, dest_lo_reg};
wire [AW-1:0] dest_idx = dest_addr[AW:1];
wire [23:0] tbl_ptr = {table_page_reg_reg, ea_reg};
wire tbl_in_array = (tbl_ptr[23:AW+1] == 0);
wire tbl_in_latch = (table_page_reg_reg == `FRWP_LATCH_PAGE);
wire [23:0] tbl_word = tbl_in_array ? flash_mem[tbl_ptr[AW:1]] : 24'h000000;
wire [5:0] lat_idx = ea_reg[6:1];
wire [15:0] row_need = row_data_packed_reg ? ROW_WORDS[15:0] + ROW_WORDS[15:0] / 16'h0002
                                : ROW_WORDS[15:0] + ROW_WORDS[15:0];
wire [16:0] src_end = {2'b00, src_reg[15:1]} + {1'b0, row_need};

// ----------------------------------------------------------------
// AHB-Lite slave: writes zero wait, reads one wait state
// ----------------------------------------------------------------
// The read wait state lets a read see a table pointer written just before.
assign hreadyout = ~rd_pend_reg;
assign hresp = 1'b0;
assign busy = (state_reg != ST_IDLE);
wire addr_ok = hsel & htrans[1] & hready;
wire wr_act = dph_wr_reg;
wire [31:0] wd = hwdata;
wire [15:0] ctrl_val = {wr_reg, prog_erase_enable_reg, sequence_error_flag_reg, 3'b000, row_data_packed_reg, underrun_error_flag_reg,
                        4'h0, op_reg};

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        dph_addr_reg <= 8'h00;
        dph_wr_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        hrdata <= 32'h00000000;
    end else begin
        dph_wr_reg <= addr_ok & hwrite;
        if (addr_ok) begin
            dph_addr_reg <= haddr[7:0];
        end
        rd_pend_reg <= addr_ok & ~hwrite;
        if (rd_pend_reg) begin
            case (dph_addr_reg)
                `FRWP_OFF_CTRL: hrdata <= {16'h0000, ctrl_val};
                `FRWP_OFF_DEST_LO: hrdata <= {16'h0000, dest_lo_reg};
                `FRWP_OFF_DEST_HI: hrdata <= {24'h000000, dest_hi_reg};
                `FRWP_OFF_SRC: hrdata <= {16'h0000, src_reg};
                `FRWP_OFF_TABLE_PAGE_REG: hrdata <= {24'h000000, table_page_reg_reg};
                `FRWP_OFF_TBL_EA: hrdata <= {16'h0000, ea_reg};
                `FRWP_OFF_TBL_LO: hrdata <= {16'h0000, tbl_word[15:0]};
                `FRWP_OFF_TBL_HI: hrdata <= {16'h0000, `FRWP_PHANTOM, tbl_word[23:16]};
                `FRWP_OFF_TBL_LO_B: hrdata <= {24'h000000, sel_byte(tbl_word[15:0], ea_reg[0])};
                `FRWP_OFF_TBL_HI_B: hrdata <= {24'h000000,
                    ea_reg[0] ? `FRWP_PHANTOM : tbl_word[23:16]};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// Holding latches, loaded only by table writes
// ----------------------------------------------------------------
always @(posedge clk) begin
    if (wr_act && tbl_in_latch) begin
        case (dph_addr_reg)
            `FRWP_OFF_TBL_LO: latch_mem[lat_idx][15:0] <= wd[15:0];
            `FRWP_OFF_TBL_HI: latch_mem[lat_idx][23:16] <= wd[7:0];
            `FRWP_OFF_TBL_LO_B: begin
                if (ea_reg[0]) begin
                    latch_mem[lat_idx][15:8] <= wd[7:0];
                end else begin
                    latch_mem[lat_idx][7:0] <= wd[7:0];
                end
            end
            `FRWP_OFF_TBL_HI_B: begin
                // Phantom byte writes have no effect
                if (!ea_reg[0]) begin
                    latch_mem[lat_idx][23:16] <= wd[7:0];
                end
            end
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// Array write port
// ----------------------------------------------------------------
reg mem_we;
reg mem_and;
reg [AW-1:0] mem_idx;
reg [23:0] mem_wdata;

always @* begin
    mem_we = 1'b0;
    mem_and = 1'b1;
    mem_idx = dest_idx;
    mem_wdata = `FRWP_ERASED;
    case (state_reg)
        ST_DWORD: begin
            mem_we = 1'b1;
            mem_idx = base_reg | {{(AW-1){1'b0}}, cnt_reg[0]};
            mem_wdata = latch_mem[{5'b00000, cnt_reg[0]}];
        end
        ST_ROWL: begin
            mem_we = 1'b1;
            mem_idx = base_reg + cnt_reg[AW-1:0];
            mem_wdata = latch_mem[cnt_reg[5:0]];
        end
        ST_FETCH: begin
            if (ram_ack && ph_reg != 2'd0) begin
                mem_we = 1'b1;
                if (row_data_packed_reg && ph_reg == 2'd1) begin
                    mem_wdata = {ram_rdata[7:0], lo_reg};
                end else if (row_data_packed_reg) begin
                    mem_wdata = {hi_reg[15:8], ram_rdata};
                end else begin
                    mem_wdata = {ram_rdata[7:0], lo_reg};
                end
            end
        end
        ST_ERASE: begin
            mem_we = 1'b1;
            mem_and = 1'b0;
            mem_idx = base_reg + cnt_reg[AW-1:0];
        end
        default: ;
    endcase
end

always @(posedge clk) begin
    if (mem_we) begin
        if (mem_and) begin
            flash_mem[mem_idx] <= flash_mem[mem_idx] & mem_wdata;
        end else begin
            flash_mem[mem_idx] <= mem_wdata;
        end
    end
end

// ----------------------------------------------------------------
// Control registers, unlock and sequencer
// ----------------------------------------------------------------
wire fetch_done = (state_reg == ST_FETCH) && ram_ack && (ph_reg != 2'd0) &&
                  (cnt_reg == last_reg);
wire fetch_wr = (state_reg == ST_FETCH) && mem_we;
wire run_done = ((state_reg == ST_DWORD || state_reg == ST_ROWL ||
                  state_reg == ST_ERASE) && cnt_reg == last_reg) || fetch_done;
wire ctrl_wr = wr_act && dph_addr_reg == `FRWP_OFF_CTRL;
wire start_req = ctrl_wr && window_reg && wd[`FRWP_BIT_WR] && wd[`FRWP_BIT_PROG_ERASE_ENABLE] &&
                 !busy;
wire [3:0] op_new = wd[`FRWP_OP_MSB:0];
wire underrun = (src_end > RAM_WORDS);

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        state_reg <= ST_IDLE;
        cnt_reg <= 16'h0000;
        last_reg <= 16'h0000;
        base_reg <= {AW{1'b0}};
        ph_reg <= 2'd0;
        lo_reg <= 16'h0000;
        hi_reg <= 16'h0000;
        wr_reg <= 1'b0;
        prog_erase_enable_reg <= 1'b0;
        sequence_error_flag_reg <= 1'b0;
        row_data_packed_reg <= 1'b0;
        underrun_error_flag_reg <= 1'b0;
        op_reg <= 4'h0;
        key_stage_reg <= 1'b0;
        window_reg <= 1'b0;
        dest_lo_reg <= 16'h0000;
        dest_hi_reg <= 8'h00;
        src_reg <= 16'h0000;
        table_page_reg_reg <= 8'h00;
        ea_reg <= 16'h0000;
        ram_req <= 1'b0;
        ram_addr <= 16'h0000;
    end else begin
        if (wr_act) begin
            // Any write other than the key pair closes the unlock window
            window_reg <= 1'b0;
            key_stage_reg <= 1'b0;
            if (dph_addr_reg == `FRWP_OFF_KEY) begin
                if (wd[7:0] == `FRWP_KEY_FIRST) begin
                    key_stage_reg <= 1'b1;
                end else if (wd[7:0] == `FRWP_KEY_SECOND && key_stage_reg) begin
                    window_reg <= 1'b1;
                end
            end
            if (!busy) begin
                case (dph_addr_reg)
                    `FRWP_OFF_DEST_LO: dest_lo_reg <= wd[15:0];
                    `FRWP_OFF_DEST_HI: dest_hi_reg <= wd[7:0];
                    `FRWP_OFF_SRC: src_reg <= wd[15:0];
                    default: ;
                endcase
            end
            if (dph_addr_reg == `FRWP_OFF_TABLE_PAGE_REG) begin
                table_page_reg_reg <= wd[7:0];
            end
            if (dph_addr_reg == `FRWP_OFF_TBL_EA) begin
                ea_reg <= wd[15:0];
            end
        end
        // Error flags clear on a written zero; a set in the same cycle wins
        if (ctrl_wr && !wd[`FRWP_BIT_SEQUENCE_ERROR_FLAG]) begin
            sequence_error_flag_reg <= 1'b0;
        end
        if (ctrl_wr && !wd[`FRWP_BIT_UNDERRUN_ERROR_FLAG]) begin
            underrun_error_flag_reg <= 1'b0;
        end
        if (ctrl_wr && !busy) begin
            prog_erase_enable_reg <= wd[`FRWP_BIT_PROG_ERASE_ENABLE];
            row_data_packed_reg <= RAM_ROW ? wd[`FRWP_BIT_ROW_DATA_PACKED] : 1'b0;
            op_reg <= op_new;
        end
        if (start_req) begin
            cnt_reg <= 16'h0000;
            ph_reg <= 2'd0;
            case (op_new)
                `FRWP_OP_DWORD: begin
                    wr_reg <= 1'b1;
                    state_reg <= ST_DWORD;
                    base_reg <= dest_idx & ~{{(AW-1){1'b0}}, 1'b1};
                    last_reg <= 16'h0001;
                end
                `FRWP_OP_ROW: begin
                    if (RAM_ROW != 0 && underrun) begin
                        underrun_error_flag_reg <= 1'b1;
                    end else begin
                        wr_reg <= 1'b1;
                        base_reg <= dest_idx & ~(ROW_WORDS[AW-1:0] - 1'b1);
                        last_reg <= ROW_WORDS[15:0] - 16'h0001;
                        state_reg <= (RAM_ROW != 0) ? ST_FETCH : ST_ROWL;
                        ram_req <= (RAM_ROW != 0);
                        ram_addr <= src_reg;
                    end
                end
                `FRWP_OP_PAGE: begin
                    wr_reg <= 1'b1;
                    state_reg <= ST_ERASE;
                    base_reg <= dest_idx & ~(PAGE_WORDS[AW-1:0] - 1'b1);
                    last_reg <= PAGE_WORDS[15:0] - 16'h0001;
                end
                `FRWP_OP_PART: begin
                    wr_reg <= 1'b1;
                    state_reg <= ST_ERASE;
                    base_reg <= {AW{1'b0}};
                    last_reg <= ARRAY_WORDS[15:0] - 16'h0001;
                end
                default: begin
                    sequence_error_flag_reg <= 1'b1;
                end
            endcase
        end
        if (state_reg != ST_IDLE && state_reg != ST_FETCH) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
        if (state_reg == ST_FETCH && ram_ack) begin
            ram_addr <= ram_addr + 16'h0002;
            if (ph_reg == 2'd0) begin
                lo_reg <= ram_rdata;
            end
            if (ph_reg == 2'd1) begin
                hi_reg <= ram_rdata;
            end
            if (row_data_packed_reg && ph_reg == 2'd1) begin
                ph_reg <= 2'd2;
            end else if (ph_reg == 2'd0) begin
                ph_reg <= 2'd1;
            end else begin
                ph_reg <= 2'd0;
            end
        end
        if (fetch_wr) begin
            {dest_hi_reg, dest_lo_reg} <= dest_addr + 24'h000002;
            cnt_reg <= cnt_reg + 16'h0001;
        end
        if (run_done) begin
            state_reg <= ST_IDLE;
            wr_reg <= 1'b0;
            ram_req <= 1'b0;
        end
    end
end

endmodule

//--- src/frwp_dummy_unused.v
// Spare source file that holds no logic
`timescale 1ns/10ps

//--- tb/frwp_assertions.sv
// Concurrent checks on the programmer's bus, start and RAM fetch ports
`timescale 1ns/10ps
`include "frwp_consts.vh"
module frwp_chk #(
    parameter ROW_WORDS = 64
) (
    input wire clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire ram_req,
    input wire [15:0] ram_addr,
    input wire ram_ack,
    input wire busy
);
// ----
// Bus phase tracking
// ----
reg wph;
reg [7:0] wa;
reg [1:0] kst;
reg [15:0] src_q;
reg row_data_packed_q;
reg [7:0] acks;
wire acc = hsel && htrans[1] && hready;
wire wdone = wph && hreadyout;
wire wkey = wdone && wa == `FRWP_OFF_KEY;
// Any other write between the keys and the start closes the window
wire go = wdone && wa == `FRWP_OFF_CTRL && kst == 2'h2 && hwdata[15] && hwdata[14] && !busy;
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wph <= 1'h0;
        wa <= 8'h0;
        kst <= 2'h0;
        src_q <= 16'h0;
        row_data_packed_q <= 1'h0;
        acks <= 8'h0;
    end else begin
        if (hreadyout) begin
            wph <= acc && hwrite;
            wa <= haddr[7:0];
        end
        if (wkey && hwdata[7:0] == `FRWP_KEY_FIRST) begin
            kst <= 2'h1;
        end else if (wkey && hwdata[7:0] == `FRWP_KEY_SECOND && kst == 2'h1) begin
            kst <= 2'h2;
        end else if (wdone) begin
            kst <= 2'h0;
        end
        if (wdone && wa == `FRWP_OFF_SRC && !busy) begin
            src_q <= hwdata[15:0];
        end
        if (go) begin
            row_data_packed_q <= hwdata[`FRWP_BIT_ROW_DATA_PACKED];
            acks <= 8'h0;
        end else if (ram_req && ram_ack) begin
            acks <= acks + 8'h1;
        end
    end
end
// ----
// Properties
// ----
default clocking cb @(posedge clk); endclocking
default disable iff (!arst_n);
sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
endsequence
sequence s_dword;
    busy [*2] ##1 !busy;
endsequence
a_resp_okay: assert property (hresp == 1'h0)
    else $error("hresp not OKAY");
a_read_wait: assert property (acc && !hwrite |=> s_rd_wait)
    else $error("read wait state wrong");
a_start_key: assert property ($rose(busy) |-> $past(go))
    else $error("operation began without unlock");
a_dword_len: assert property (go && hwdata[3:0] == `FRWP_OP_DWORD |=> s_dword)
    else $error("double word length wrong");
a_bad_op: assert property (go && (hwdata[3:0] == 4'h0 || hwdata[3:0] > 4'h4) |=> !busy [*2])
    else $error("reserved op started");
a_ram_busy: assert property (ram_req |-> busy)
    else $error("fetch outside operation");
a_addr_start: assert property ($rose(ram_req) |-> ram_addr == src_q)
    else $error("fetch start address wrong");
a_addr_step: assert property (ram_req && ram_ack |=> ram_addr == $past(ram_addr) + 16'h2)
    else $error("fetch address step wrong");
a_ack_count: assert property ($fell(ram_req) |-> acks == (row_data_packed_q ? ROW_WORDS * 3 / 2 : ROW_WORDS * 2))
    else $error("fetched word count wrong");
endmodule

bind frwp_top frwp_chk #(.ROW_WORDS(ROW_WORDS)) u_chk (.clk(clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .ram_req(ram_req), .ram_addr(ram_addr),
    .ram_ack(ram_ack), .busy(busy));

//--- tb/frwp_ram_model.sv
// Data RAM partner answering row fetches, promptly or with a delay
`timescale 1ns/10ps
module frwp_ram_model (
    input wire clk,
    input wire arst_n,
    input wire slow,
    input wire ram_req,
    input wire [15:0] ram_addr,
    output reg [15:0] ram_rdata = 16'hA5A5,
    output reg ram_ack = 1'h0
);
reg [15:0] mem [0:32767];
reg [1:0] dly = 2'h0;
// Data toggles between acks so stale words never look valid
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        ram_ack <= 1'h0;
        dly <= 2'h0;
    end else begin
        ram_ack <= 1'h0;
        ram_rdata <= ~ram_rdata;
        if (ram_req && !ram_ack && dly == 2'h0) begin
            ram_ack <= 1'h1;
            ram_rdata <= mem[ram_addr[15:1]];
            dly <= slow ? ram_addr[3:2] : 2'h0;
        end else if (ram_req && !ram_ack) begin
            dly <= dly - 2'h1;
        end
    end
end
endmodule

//--- tb/frwp_top_test.sv
// Self-checking bench for the flash row/word programmer
`timescale 1ns/10ps
`include "frwp_consts.vh"
module frwp_top_test;
// ----
// Stimulus and results
// ----
reg clk = 1'h0, arst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, slow = 1'h0, rph = 1'h0;
reg [1:0] htrans = 2'h0;
reg [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h61, r1, r2, r3, r4;
reg [23:0] e;
reg [31:0] exp_q[$];
wire hreadyout, hresp, ram_req, ram_ack, busy;
wire [31:0] hrdata;
wire [15:0] ram_addr, ram_rdata;
integer miscompares = 0, n_compared = 0, cyc = 0, i, k, b;
localparam W = 1'h1, R = 1'h0;
always #25 clk = ~clk;
frwp_top uut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ram_req(ram_req),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack), .busy(busy));
frwp_ram_model uram (.clk(clk), .arst_n(arst_n), .slow(slow), .ram_req(ram_req),
    .ram_addr(ram_addr), .ram_rdata(ram_rdata), .ram_ack(ram_ack));
function [31:0] nxt(input [31:0] s);
    reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        nxt = t ^ (t << 5);
    end
endfunction
task conclude;
    begin
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    end
endtask
task cmp(input [31:0] ex, input [31:0] got);
    begin
        n_compared = n_compared + 1;
        if (got !== ex) begin
            miscompares = miscompares + 1;
            $display("ERROR hrdata expected %h seen %h", ex, got);
        end
    end
endtask
task lvl(input [71:0] nm, input got, input ex);
    begin
        n_compared = n_compared + 1;
        if (got !== ex) begin
            miscompares = miscompares + 1;
            $display("ERROR %0s expected %b seen %b", nm, ex, got);
        end
    end
endtask
// Read data is judged by the monitor when the second data edge comes
always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
        miscompares = miscompares + 1;
        conclude;
    end
    if (rph && hreadyout) begin
        cmp(exp_q.pop_front(), hrdata);
        rph = 1'h0;
    end
    if (hsel && htrans[1] && !hwrite && hreadyout) rph = 1'h1;
end
// ----
// Bus tasks
// ----
task bus(input w, input [7:0] a, input [31:0] d);
    begin
        if (!w) exp_q.push_back(d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
    end
endtask
task go(input [15:0] c);
    begin
        // Key pair and start go out back to back, as with interrupts masked
        bus(W, `FRWP_OFF_KEY, 32'h55);
        bus(W, `FRWP_OFF_KEY, 32'hAA);
        bus(W, `FRWP_OFF_CTRL, {16'h0, c});
    end
endtask
task idle;
    begin
        @(posedge clk);
        while (busy !== 1'h0) @(posedge clk);
    end
endtask
task tw(input [15:0] ea, input [23:0] x);
    begin
        bus(W, `FRWP_OFF_TBL_EA, {16'h0, ea});
        bus(R, `FRWP_OFF_TBL_LO, {16'h0, x[15:0]});
        bus(R, `FRWP_OFF_TBL_HI, {24'h0, x[23:16]});
    end
endtask
task lat(input [15:0] ea, input [31:0] d);
    begin
        bus(W, `FRWP_OFF_TBL_EA, {16'h0, ea});
        bus(W, `FRWP_OFF_TBL_LO, d);
        bus(W, `FRWP_OFF_TBL_HI, d >> 16);
    end
endtask
// ----
// Main sequence
// ----
initial begin
    repeat (8) @(posedge clk);
    lvl("hreadyout", hreadyout, 1'h1);
    lvl("busy", busy, 1'h0);
    lvl("ram_req", ram_req, 1'h0);
    arst_n <= 1'h1;
    for (i = 0; i < 1024; i = i + 1) begin
        seed = nxt(seed);
        uram.mem[i] = seed[15:0];
    end
    r1 = nxt(seed);
    r2 = nxt(r1);
    r3 = nxt(r2);
    r4 = nxt(r3);
    @(posedge clk);
    bus(R, `FRWP_OFF_CTRL, 32'h0);
    bus(R, `FRWP_OFF_KEY, 32'h0);
    bus(R, 8'h40, 32'h0);
    go(16'hC004);
    idle;
    bus(R, `FRWP_OFF_CTRL, 32'h4004);
    bus(W, `FRWP_OFF_TABLE_PAGE_REG, 32'h0);
    tw(16'h0010, 24'hFFFFFF);
    bus(W, `FRWP_OFF_TABLE_PAGE_REG, 32'hFA);
    lat(16'h0000, r1);
    lat(16'h0002, r2);
    bus(W, `FRWP_OFF_DEST_LO, 32'h0010);
    bus(W, `FRWP_OFF_DEST_HI, 32'h0);
    bus(R, `FRWP_OFF_CTRL, 32'h4004);
    go(16'hC001);
    idle;
    bus(W, `FRWP_OFF_TABLE_PAGE_REG, 32'h0);
    tw(16'h0010, r1[23:0]);
    tw(16'h0012, r2[23:0]);
    bus(W, `FRWP_OFF_TABLE_PAGE_REG, 32'hFA);
    lat(16'h0000, r3);
    bus(W, `FRWP_OFF_TBL_EA, 32'h1);
    bus(W, `FRWP_OFF_TBL_LO_B, 32'h0);
    bus(W, `FRWP_OFF_TBL_HI_B, 32'h0);
    lat(16'h0002, r4);
    bus(W, `FRWP_OFF_TABLE_PAGE_REG, 32'h0);
    tw(16'h0000, 24'hFFFFFF);
    go(16'hC001);
    idle;
    tw(16'h0010, r1[23:0] & {r3[23:16], 8'h00, r3[7:0]});
    tw(16'h0012, r2[23:0] & r4[23:0]);
    bus(W, `FRWP_OFF_KEY, 32'h55);
    bus(W, `FRWP_OFF_KEY, 32'hAA);
    bus(W, `FRWP_OFF_SRC, 32'h0);
    bus(W, `FRWP_OFF_CTRL, 32'hC001);
    bus(R, `FRWP_OFF_CTRL, 32'h4001);
    go(16'h8001);
    bus(R, `FRWP_OFF_CTRL, 32'h0001);
    for (i = 0; i < 16; i = i + 1) begin
        if (i == 0 || i > 4) begin
            go(16'hC000 | i[3:0]);
            bus(R, `FRWP_OFF_CTRL, 32'h6000 | i[3:0]);
        end
    end
    bus(W, `FRWP_OFF_CTRL, 32'h4000);
    bus(R, `FRWP_OFF_CTRL, 32'h4000);
    go(16'hC003);
    idle;
    tw(16'h0010, 24'hFFFFFF);
    bus(W, `FRWP_OFF_SRC, 32'h0100);
    bus(W, `FRWP_OFF_DEST_LO, 32'h0080);
    go(16'hC002);
    idle;
    bus(R, `FRWP_OFF_DEST_LO, 32'h0100);
    for (k = 0; k < 64; k = k + 63) begin
        e = {uram.mem[129 + 2 * k][7:0], uram.mem[128 + 2 * k]};
        tw(16'h0080 + 2 * k, e);
    end
    slow <= 1'h1;
    bus(W, `FRWP_OFF_SRC, 32'h0400);
    bus(W, `FRWP_OFF_DEST_LO, 32'h0100);
    go(16'hC202);
    idle;
    bus(R, `FRWP_OFF_DEST_LO, 32'h0180);
    for (k = 0; k < 32; k = k + 31) begin
        b = 512 + 3 * k;
        tw(16'h0100 + 4 * k, {uram.mem[b + 1][7:0], uram.mem[b]});
        tw(16'h0102 + 4 * k, {uram.mem[b + 1][15:8], uram.mem[b + 2]});
    end
    bus(W, `FRWP_OFF_SRC, 32'hFFF0);
    go(16'hC002);
    bus(R, `FRWP_OFF_CTRL, 32'h4102);
    conclude;
end
endmodule
